// ===== src/ccrb_pkg.sv
// Constants, opcodes and states for the processor control register block.
// Assumes a 64 KB byte address space and an 8-bit data path.
package ccrb_pkg;

  // Address space layout
  localparam logic [15:0] CCRB_VEC_BASE = 16'h0000;
  localparam logic [15:0] CCRB_VEC_END = 16'h003F;
  localparam logic [15:0] CCRB_RST_VEC = 16'h0000;
  localparam logic [15:0] CCRB_BRK_VEC = 16'h003E;
  localparam logic [15:0] CCRB_TCALL_BASE = 16'h0040;
  localparam logic [15:0] CCRB_TCALL_END = 16'h007F;
  localparam logic [15:0] CCRB_FCALL_BASE = 16'h0800;
  localparam logic [15:0] CCRB_FCALL_END = 16'h0FFF;
  localparam logic [15:0] CCRB_RAM_START_SMALL = 16'hFD00;
  localparam logic [15:0] CCRB_RAM_START_LARGE = 16'hFB00;
  localparam logic [15:0] CCRB_RAM_END = 16'hFEFF;
  localparam logic [15:0] CCRB_STACK_EMPTY = 16'hFF00;
  localparam logic [15:0] CCRB_BANK_BASE = 16'hFEE0;
  localparam logic [15:0] CCRB_BANK_END = 16'hFEFF;
  localparam logic [15:0] CCRB_SFR_BASE = 16'hFF00;
  localparam logic [15:0] CCRB_SFR_END = 16'hFFFF;

  // Status word bit positions and reset value
  localparam int CCRB_PSW_IE = 7;
  localparam int CCRB_PSW_Z = 6;
  localparam int CCRB_PSW_BANK_SELECT_HIGH = 5;
  localparam int CCRB_PSW_AC = 4;
  localparam int CCRB_PSW_BANK_SELECT_LOW = 3;
  localparam int CCRB_PSW_ISP = 1;
  localparam int CCRB_PSW_CY = 0;
  localparam logic [7:0] CCRB_PSW_RESET = 8'h02;
  localparam logic [15:0] CCRB_SP_RESET = 16'h0000;

  // Register port offsets
  localparam logic [7:0] CCRB_OFS_PC_LO = 8'h00;
  localparam logic [7:0] CCRB_OFS_PC_HI = 8'h01;
  localparam logic [7:0] CCRB_OFS_PSW = 8'h02;
  localparam logic [7:0] CCRB_OFS_SP_LO = 8'h03;
  localparam logic [7:0] CCRB_OFS_SP_HI = 8'h04;
  localparam logic [7:0] CCRB_OFS_STAT = 8'h05;
  localparam logic [7:0] CCRB_OFS_BANK = 8'h20;

  typedef enum logic [4:0] {
    CCRB_OP_SEQ = 5'h00, CCRB_OP_BRANCH = 5'h01, CCRB_OP_CALL = 5'h02,
    CCRB_OP_TABLE_CALL = 5'h03, CCRB_OP_FIXED_CALL = 5'h04, CCRB_OP_RET = 5'h05,
    CCRB_OP_IRQ_RETURN = 5'h06, CCRB_OP_BREAK_RETURN = 5'h07, CCRB_OP_SOFT_BREAK = 5'h08,
    CCRB_OP_PUSH_PSW = 5'h09, CCRB_OP_POP_PSW = 5'h0A, CCRB_OP_PUSH_RP = 5'h0B,
    CCRB_OP_POP_RP = 5'h0C, CCRB_OP_MASK_ALL = 5'h0D, CCRB_OP_UNMASK = 5'h0E,
    CCRB_OP_BANK_SWITCH = 5'h0F, CCRB_OP_LOAD_SP = 5'h10
  } ccrb_op_t;

  typedef enum logic [2:0] {
    CCRB_ST_VEC_RD0 = 3'b000, CCRB_ST_VEC_RD1 = 3'b001, CCRB_ST_VEC_CAP = 3'b010,
    CCRB_ST_IDLE = 3'b011, CCRB_ST_PUSH = 3'b100, CCRB_ST_POP = 3'b101
  } ccrb_state_t;

  typedef enum logic [2:0] {
    CCRB_RG_VECTOR = 3'b000, CCRB_RG_TABLE = 3'b001, CCRB_RG_FIXED = 3'b010,
    CCRB_RG_RAM = 3'b011, CCRB_RG_BANK = 3'b100, CCRB_RG_SFR = 3'b101,
    CCRB_RG_OTHER = 3'b110
  } ccrb_region_t;

endpackage : ccrb_pkg

// ===== src/ccrb_core_regs.sv
// Program counter, status word, stack pointer and working register banks.
// Assumes a decoder that issues one op at a time and a zero-wait memory.
// Notes on behaviour
// - Table calls fetch their entry address from 0040H..007FH.
// - Fixed-area calls target 0800H..0FFFH.
// - High-speed RAM ends at FEFFH, starting FD00H or FB00H by variant.
// - FEE0H..FEFFH hold four banks of eight byte registers.
// - FF00H..FFFFH belong to peripheral registers; unassigned ones untouched.
// - Sequential flow advances the 16-bit counter by instruction length.
// - A branch loads the counter with its immediate or register target.
// - Reset loads the counter from vector bytes 0000H and 0001H.
// - Status word is eight flag bits, 02H after reset.
// - Status word is pushed on interrupt, break or push, restored on interrupt/break returns or pop.
// - Accept flag low refuses maskable interrupts; high defers to masks, priority.
// - Mask-all or acknowledge clears the accept flag; unmask sets it.
// - Zero flag is one exactly when the result is zero.
// - Two-bit bank select chooses the active bank; bank switch writes it.
// - Half-carry flags a carry out of or borrow into bit 3.
// - In-service flag low refuses low-priority requests; accept flag still needed.
// - Carry holds add/sub overflow, rotate shift-out, bit accumulator.
// - Stack pointer is 16 bits; software keeps the stack in RAM.
// - Stack pointer decrements before each save, increments after each restore.
// - Stack pointer resets to 0000H; software loads it before use.
// - Byte registers pair into four words; named or absolute indexing.
// - 0000H..003FH is the vector area for reset and interrupts.
// - Vector entries keep low byte at even, high byte at odd address.
`timescale 1ns/1ps
module ccrb_core_regs #(
  parameter logic RAM_LARGE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic op_valid,
  input wire ccrb_pkg::ccrb_op_t op_code,
  input wire logic [2:0] op_len,
  input wire logic [15:0] op_target,
  input wire logic [1:0] op_sel,
  output logic op_ready,
  input wire logic alu_upd,
  input wire logic alu_sub,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  output logic [7:0] alu_result,
  input wire logic cy_we,
  input wire logic cy_in,
  input wire logic [2:0] gr_rd_idx,
  output logic [7:0] gr_rd_data,
  input wire logic [1:0] gr_rp_idx,
  output logic [15:0] gr_rp_data,
  input wire logic gr_wr,
  input wire logic [2:0] gr_wr_idx,
  input wire logic [7:0] gr_wr_data,
  input wire logic gr_rpw,
  input wire logic [1:0] gr_rpw_idx,
  input wire logic [15:0] gr_rpw_data,
  input wire logic irq_req,
  input wire logic irq_masked,
  input wire logic irq_low_prio,
  input wire logic [15:0] irq_vector,
  output logic irq_accept,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] next_instr_pointer,
  output logic [7:0] proc_status_word,
  output logic [15:0] stack_top_pointer,
  output logic [1:0] bank_active,
  output logic [2:0] pc_region,
  output logic pc_fault,
  output logic sp_fault
);
  import ccrb_pkg::*;

  localparam logic [15:0] RAM_START = RAM_LARGE ? CCRB_RAM_START_LARGE : CCRB_RAM_START_SMALL;

  function automatic ccrb_region_t classify(input logic [15:0] a);
    ccrb_region_t r;
    r = CCRB_RG_OTHER;
    if (a <= CCRB_VEC_END) r = CCRB_RG_VECTOR;
    else if (a >= CCRB_TCALL_BASE && a <= CCRB_TCALL_END) r = CCRB_RG_TABLE;
    else if (a >= CCRB_FCALL_BASE && a <= CCRB_FCALL_END) r = CCRB_RG_FIXED;
    else if (a >= CCRB_BANK_BASE && a <= CCRB_BANK_END) r = CCRB_RG_BANK;
    else if (a >= RAM_START && a <= CCRB_RAM_END) r = CCRB_RG_RAM;
    else if (a >= CCRB_SFR_BASE) r = CCRB_RG_SFR;
    return r;
  endfunction : classify

  ccrb_state_t state_reg, state_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] psw_reg, psw_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] vaddr_reg, pend_pc_reg;
  logic [7:0] vlo_reg;
  logic vec_reset_reg, vec_done_reg, sp_loaded_reg;
  logic [23:0] buf_reg;
  logic [1:0] cnt_reg;
  logic pend_reg;
  ccrb_op_t kind_reg;
  logic rd_bank_q;
  logic [7:0] bank_q;
  logic [7:0] gr_mem [0:31];
  logic [7:0] alu_res_reg;

  // Address decode and helpers
  wire logic [1:0] rbs = {psw_reg[CCRB_PSW_BANK_SELECT_HIGH], psw_reg[CCRB_PSW_BANK_SELECT_LOW]};
  wire logic [15:0] pc_ret = pc_reg + {13'h0000, op_len};
  wire logic is_idle = state_reg == CCRB_ST_IDLE;
  wire logic in_service_level_flag = psw_reg[CCRB_PSW_ISP];
  wire logic can_accept = psw_reg[CCRB_PSW_IE] && !irq_masked
    && (in_service_level_flag || !irq_low_prio);
  assign irq_accept = is_idle && can_accept;
  wire logic irq_take = irq_req && irq_accept;
  assign op_ready = is_idle && !irq_take;
  wire logic op_go = op_valid && op_ready;
  wire logic [4:0] rp_lo = {rbs, op_sel, 1'b0};
  wire logic [15:0] rp_word = {gr_mem[rp_lo | 5'h01], gr_mem[rp_lo]};
  wire logic [15:0] fcall_tgt = CCRB_FCALL_BASE | {5'h00, op_target[10:0]};
  wire logic [15:0] tcall_addr = CCRB_TCALL_BASE | {10'h000, op_target[4:0], 1'b0};

  // Stack and vector memory engine
  wire logic eng_wr = state_reg == CCRB_ST_PUSH;
  wire logic eng_rd = state_reg == CCRB_ST_VEC_RD0 || state_reg == CCRB_ST_VEC_RD1
    || (state_reg == CCRB_ST_POP && cnt_reg != 2'd0);
  wire logic [15:0] sp_dec = sp_reg - 16'h0001;
  wire logic [15:0] eng_addr = eng_wr ? sp_dec :
    (state_reg == CCRB_ST_VEC_RD0) ? vaddr_reg :
    (state_reg == CCRB_ST_VEC_RD1) ? (vaddr_reg | 16'h0001) : sp_reg;
  wire logic eng_in_bank = eng_addr >= CCRB_BANK_BASE && eng_addr <= CCRB_BANK_END;
  wire logic [4:0] eng_flat = {~eng_addr[4:3], eng_addr[2:0]};
  assign mem_req = (eng_rd || eng_wr) && !eng_in_bank;
  assign mem_we = eng_wr && !eng_in_bank;
  assign mem_addr = eng_addr;
  assign mem_wdata = buf_reg[23:16];
  wire logic [7:0] eff_rdata = rd_bank_q ? bank_q : mem_rdata;
  wire logic pop_fin = state_reg == CCRB_ST_POP && cnt_reg == 2'd0 && pend_reg;
  wire logic [23:0] fin = {eff_rdata, buf_reg[23:8]};
  wire logic restores_psw = kind_reg == CCRB_OP_IRQ_RETURN
    || kind_reg == CCRB_OP_BREAK_RETURN || kind_reg == CCRB_OP_POP_PSW;

  // Bank write ports: byte port and pair port
  wire logic bus_bank = bus_addr >= CCRB_OFS_BANK;
  wire logic [4:0] bus_flat = bus_addr[4:0];
  wire logic wa_eng = eng_wr && eng_in_bank;
  wire logic wa_en = wa_eng || gr_wr || (bus_wr && bus_bank);
  wire logic [4:0] wa_idx = wa_eng ? eng_flat : gr_wr ? {rbs, gr_wr_idx} : bus_flat;
  wire logic [7:0] wa_data = wa_eng ? buf_reg[23:16] : gr_wr ? gr_wr_data : bus_wdata;
  wire logic wp_pop = pop_fin && kind_reg == CCRB_OP_POP_RP;
  wire logic wp_en = wp_pop || gr_rpw;
  wire logic [3:0] wp_idx = wp_pop ? {rbs, buf_reg[9:8]} : {rbs, gr_rpw_idx};
  wire logic [15:0] wp_data = wp_pop ? fin[23:8] : gr_rpw_data;

  // Flag arithmetic
  wire logic [8:0] alu_sum = alu_sub ? ({1'b0, alu_a} - {1'b0, alu_b})
    : ({1'b0, alu_a} + {1'b0, alu_b});
  wire logic alu_half = alu_a[4] ^ alu_b[4] ^ alu_sum[4];

  // Status word next value
  always_comb begin
    psw_next = psw_reg;
    if (bus_wr && bus_addr == CCRB_OFS_PSW) psw_next = bus_wdata;
    if (alu_upd) begin
      psw_next[CCRB_PSW_Z] = alu_sum[7:0] == 8'h00;
      psw_next[CCRB_PSW_AC] = alu_half;
      psw_next[CCRB_PSW_CY] = alu_sum[8];
    end
    if (cy_we) psw_next[CCRB_PSW_CY] = cy_in;
    if (op_go) begin
      case (op_code)
        CCRB_OP_MASK_ALL: psw_next[CCRB_PSW_IE] = 1'b0;
        CCRB_OP_UNMASK: psw_next[CCRB_PSW_IE] = 1'b1;
        CCRB_OP_BANK_SWITCH: begin
          psw_next[CCRB_PSW_BANK_SELECT_HIGH] = op_sel[1];
          psw_next[CCRB_PSW_BANK_SELECT_LOW] = op_sel[0];
        end
        default: psw_next = psw_next;
      endcase
    end
    if (irq_take) begin
      psw_next[CCRB_PSW_IE] = 1'b0;
      psw_next[CCRB_PSW_ISP] = irq_low_prio;
    end
    if (pop_fin && restores_psw) psw_next = fin[23:16];
  end

  // Counter, stack pointer and sequencer next values
  always_comb begin
    pc_next = pc_reg;
    sp_next = sp_reg;
    state_next = state_reg;
    if (bus_wr && bus_addr == CCRB_OFS_SP_LO) sp_next[7:0] = bus_wdata;
    if (bus_wr && bus_addr == CCRB_OFS_SP_HI) sp_next[15:8] = bus_wdata;
    case (state_reg)
      CCRB_ST_VEC_RD0: state_next = CCRB_ST_VEC_RD1;
      CCRB_ST_VEC_RD1: state_next = CCRB_ST_VEC_CAP;
      CCRB_ST_VEC_CAP: begin
        if (vec_reset_reg) begin
          pc_next = {eff_rdata, vlo_reg};
          state_next = CCRB_ST_IDLE;
        end else begin
          state_next = CCRB_ST_PUSH;
        end
      end
      CCRB_ST_PUSH: begin
        sp_next = sp_dec;
        if (cnt_reg == 2'd1) begin
          state_next = CCRB_ST_IDLE;
          if (kind_reg != CCRB_OP_PUSH_PSW && kind_reg != CCRB_OP_PUSH_RP) begin
            pc_next = pend_pc_reg;
          end
        end
      end
      CCRB_ST_POP: begin
        if (cnt_reg != 2'd0) sp_next = sp_reg + 16'h0001;
        if (pop_fin) begin
          state_next = CCRB_ST_IDLE;
          if (kind_reg == CCRB_OP_RET) pc_next = fin[23:8];
          if (kind_reg == CCRB_OP_IRQ_RETURN || kind_reg == CCRB_OP_BREAK_RETURN) begin
            pc_next = fin[15:0];
          end
        end
      end
      CCRB_ST_IDLE: begin
        if (irq_take) begin
          state_next = CCRB_ST_VEC_RD0;
        end else if (op_go) begin
          case (op_code)
            CCRB_OP_SEQ: pc_next = pc_ret;
            CCRB_OP_BRANCH: pc_next = op_target;
            CCRB_OP_CALL, CCRB_OP_FIXED_CALL, CCRB_OP_PUSH_PSW, CCRB_OP_PUSH_RP: begin
              state_next = CCRB_ST_PUSH;
              if (op_code == CCRB_OP_PUSH_PSW || op_code == CCRB_OP_PUSH_RP) pc_next = pc_ret;
            end
            CCRB_OP_TABLE_CALL, CCRB_OP_SOFT_BREAK: state_next = CCRB_ST_VEC_RD0;
            CCRB_OP_RET, CCRB_OP_IRQ_RETURN, CCRB_OP_BREAK_RETURN: state_next = CCRB_ST_POP;
            CCRB_OP_POP_PSW, CCRB_OP_POP_RP: begin
              state_next = CCRB_ST_POP;
              pc_next = pc_ret;
            end
            CCRB_OP_LOAD_SP: begin
              sp_next = op_target;
              pc_next = pc_ret;
            end
            default: pc_next = pc_ret;
          endcase
        end
      end
      default: state_next = CCRB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CCRB_ST_VEC_RD0;
      pc_reg <= 16'h0000;
      psw_reg <= CCRB_PSW_RESET;
      sp_reg <= CCRB_SP_RESET;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      psw_reg <= psw_next;
      sp_reg <= sp_next;
    end
  end

  // Engine working state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vaddr_reg <= CCRB_RST_VEC;
      vec_reset_reg <= 1'b1;
      vec_done_reg <= 1'b0;
      sp_loaded_reg <= 1'b0;
      pend_pc_reg <= 16'h0000;
      vlo_reg <= 8'h00;
      buf_reg <= 24'h000000;
      cnt_reg <= 2'd0;
      pend_reg <= 1'b0;
      kind_reg <= CCRB_OP_SEQ;
      rd_bank_q <= 1'b0;
      bank_q <= 8'h00;
    end else begin
      rd_bank_q <= eng_rd && eng_in_bank;
      bank_q <= gr_mem[eng_flat];
      pend_reg <= state_reg == CCRB_ST_POP && cnt_reg != 2'd0;
      if (state_reg == CCRB_ST_VEC_RD1) vlo_reg <= eff_rdata;
      if (state_reg == CCRB_ST_VEC_CAP) begin
        vec_done_reg <= 1'b1;
        vec_reset_reg <= 1'b0;
        pend_pc_reg <= {eff_rdata, vlo_reg};
      end
      if ((op_go && op_code == CCRB_OP_LOAD_SP) || (bus_wr && bus_addr == CCRB_OFS_SP_HI)) begin
        sp_loaded_reg <= 1'b1;
      end
      if (eng_wr) begin
        buf_reg <= {buf_reg[15:0], 8'h00};
        cnt_reg <= cnt_reg - 2'd1;
      end
      if (state_reg == CCRB_ST_POP) begin
        if (cnt_reg != 2'd0) cnt_reg <= cnt_reg - 2'd1;
        if (pend_reg) buf_reg <= fin;
      end
      if (irq_take) begin
        kind_reg <= CCRB_OP_SOFT_BREAK;
        vaddr_reg <= irq_vector;
        buf_reg <= {psw_reg, pc_reg};
        cnt_reg <= 2'd3;
      end else if (op_go) begin
        kind_reg <= op_code;
        case (op_code)
          CCRB_OP_CALL, CCRB_OP_FIXED_CALL, CCRB_OP_TABLE_CALL: begin
            buf_reg <= {pc_ret, 8'h00};
            cnt_reg <= 2'd2;
            pend_pc_reg <= (op_code == CCRB_OP_CALL) ? op_target : fcall_tgt;
            vaddr_reg <= tcall_addr;
          end
          CCRB_OP_SOFT_BREAK: begin
            buf_reg <= {psw_reg, pc_ret};
            cnt_reg <= 2'd3;
            vaddr_reg <= CCRB_BRK_VEC;
          end
          CCRB_OP_PUSH_PSW: begin
            buf_reg <= {psw_reg, 16'h0000};
            cnt_reg <= 2'd1;
          end
          CCRB_OP_PUSH_RP: begin
            buf_reg <= {rp_word, 8'h00};
            cnt_reg <= 2'd2;
          end
          CCRB_OP_RET, CCRB_OP_POP_RP: begin
            buf_reg <= {6'h00, op_sel, 16'h0000};
            cnt_reg <= 2'd2;
          end
          CCRB_OP_IRQ_RETURN, CCRB_OP_BREAK_RETURN: cnt_reg <= 2'd3;
          CCRB_OP_POP_PSW: cnt_reg <= 2'd1;
          default: cnt_reg <= cnt_reg;
        endcase
      end
    end
  end

  // Working register banks, one write mux per byte
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bank
      localparam logic [4:0] IDX = 5'(gi);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          gr_mem[gi] <= 8'h00;
        end else if (wp_en && wp_idx == IDX[4:1]) begin
          gr_mem[gi] <= IDX[0] ? wp_data[15:8] : wp_data[7:0];
        end else if (wa_en && wa_idx == IDX) begin
          gr_mem[gi] <= wa_data;
        end
      end
    end
  endgenerate

  // Register reads and flag result
  wire logic [4:0] rp_rd_lo = {rbs, gr_rp_idx, 1'b0};
  wire logic [7:0] stat_byte = {4'h0, sp_loaded_reg, sp_fault, pc_fault, vec_done_reg};
  wire logic [7:0] bus_mux = bus_bank ? gr_mem[bus_flat] :
    (bus_addr == CCRB_OFS_PC_LO) ? pc_reg[7:0] :
    (bus_addr == CCRB_OFS_PC_HI) ? pc_reg[15:8] :
    (bus_addr == CCRB_OFS_PSW) ? psw_reg :
    (bus_addr == CCRB_OFS_SP_LO) ? sp_reg[7:0] :
    (bus_addr == CCRB_OFS_SP_HI) ? sp_reg[15:8] :
    (bus_addr == CCRB_OFS_STAT) ? stat_byte : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 8'h00;
      gr_rd_data <= 8'h00;
      gr_rp_data <= 16'h0000;
      alu_res_reg <= 8'h00;
    end else begin
      bus_rdata <= bus_rd ? bus_mux : 8'h00;
      gr_rd_data <= gr_mem[{rbs, gr_rd_idx}];
      gr_rp_data <= {gr_mem[rp_rd_lo | 5'h01], gr_mem[rp_rd_lo]};
      if (alu_upd) alu_res_reg <= alu_sum[7:0];
    end
  end

  // Observation outputs
  assign alu_result = alu_res_reg;
  assign next_instr_pointer = pc_reg;
  assign proc_status_word = psw_reg;
  assign stack_top_pointer = sp_reg;
  assign bank_active = rbs;
  assign pc_region = classify(pc_reg);
  assign pc_fault = pc_reg >= CCRB_BANK_BASE && pc_reg <= CCRB_BANK_END;
  assign sp_fault = sp_reg < RAM_START || sp_reg > CCRB_STACK_EMPTY;

endmodule : ccrb_core_regs

// ===== tb/ccrb_core_regs_monitor.sv
// Checker for the control register block, bound to its top module.
// Assumes one clock domain and the bench as op and interrupt source.
`timescale 1ns/1ps
module ccrb_core_regs_monitor
  import ccrb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire ccrb_pkg::ccrb_op_t op_code,
  input wire logic [2:0] op_len,
  input wire logic [15:0] op_target,
  input wire logic [1:0] op_sel,
  input wire logic op_ready,
  input wire logic alu_upd,
  input wire logic [7:0] alu_result,
  input wire logic irq_req,
  input wire logic irq_low_prio,
  input wire logic irq_accept,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] next_instr_pointer,
  input wire logic [7:0] proc_status_word,
  input wire logic [15:0] stack_top_pointer,
  input wire logic [1:0] bank_active,
  input wire logic pc_fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire go = op_valid && op_ready;
  property p_ie_gate;
    !proc_status_word[CCRB_PSW_IE] |-> !irq_accept;
  endproperty
  a_ie_gate: assert property (p_ie_gate) else $error("accept while disabled");
  property p_isp_gate;
    !proc_status_word[CCRB_PSW_ISP] && irq_low_prio |-> !irq_accept;
  endproperty
  a_isp_gate: assert property (p_isp_gate) else $error("low level accepted");
  property p_ack_clear;
    irq_req && irq_accept |=> !proc_status_word[CCRB_PSW_IE];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("accept flag kept");
  property p_seq;
    go && op_code == CCRB_OP_SEQ |=>
      next_instr_pointer == 16'($past(next_instr_pointer) + $past(op_len));
  endproperty
  a_seq: assert property (p_seq) else $error("counter step wrong");
  property p_branch;
    go && op_code == CCRB_OP_BRANCH |=> next_instr_pointer == $past(op_target);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_bank;
    go && op_code == CCRB_OP_BANK_SWITCH |=> bank_active == $past(op_sel) ##1
      bank_active == {proc_status_word[CCRB_PSW_BANK_SELECT_HIGH], proc_status_word[CCRB_PSW_BANK_SELECT_LOW]};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_zero;
    alu_upd |=> proc_status_word[CCRB_PSW_Z] == (alu_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_fault;
    pc_fault == (next_instr_pointer inside {[CCRB_BANK_BASE:CCRB_BANK_END]});
  endproperty
  a_fault: assert property (p_fault) else $error("bank fetch flag wrong");
  sequence s_call_go;
    go && op_code == CCRB_OP_CALL && stack_top_pointer <= CCRB_BANK_BASE;
  endsequence
  sequence s_call_push;
    mem_we && mem_addr == 16'($past(stack_top_pointer) - 16'h0001) ##1
      mem_we && mem_addr == 16'($past(stack_top_pointer, 2) - 16'h0002);
  endsequence
  property p_call;
    s_call_go |=> s_call_push;
  endproperty
  a_call: assert property (p_call) else $error("call push order wrong");
endmodule : ccrb_core_regs_monitor
bind ccrb_core_regs ccrb_core_regs_monitor i_ccrb_core_regs_monitor (
  .clk, .rstn, .op_valid, .op_code, .op_len, .op_target, .op_sel, .op_ready, .alu_upd,
  .alu_result, .irq_req, .irq_low_prio, .irq_accept, .mem_we, .mem_addr, .next_instr_pointer,
  .proc_status_word, .stack_top_pointer, .bank_active, .pc_fault
);

// ===== tb/test_ccrb_core_regs.sv
// Self-checking bench for the control register block.
// Assumes the bench plays decoder, interrupt source and zero-wait memory.
`timescale 1ns/1ps
module test_ccrb_core_regs;
  import ccrb_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bus_wr = 1'b0, bus_rd = 1'b0, op_valid = 1'b0, alu_upd = 1'b0, alu_sub = 1'b0;
  logic cy_we = 1'b0, cy_in = 1'b0, gr_wr = 1'b0, gr_rpw = 1'b0, irq_req = 1'b0;
  logic irq_masked = 1'b0, irq_low_prio = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
  logic [7:0] gr_wr_data = 8'h00, mem_rdata = 8'h00, d;
  logic [2:0] op_len = 3'h0, gr_rd_idx = 3'h0, gr_wr_idx = 3'h0, pc_region;
  logic [1:0] op_sel = 2'h0, gr_rp_idx = 2'h0, gr_rpw_idx = 2'h0, bank_active;
  logic [15:0] op_target = 16'h0000, gr_rpw_data = 16'h0000, irq_vector = 16'h0000;
  ccrb_op_t op_code = CCRB_OP_SEQ;
  logic [7:0] bus_rdata, alu_result, gr_rd_data, mem_wdata, proc_status_word;
  logic [15:0] gr_rp_data, mem_addr, next_instr_pointer, stack_top_pointer;
  logic op_ready, irq_accept, mem_req, mem_we, pc_fault, sp_fault;
  logic [7:0] mem [0:65535];
  int mismatches = 0, total_checks = 0;
  logic [15:0] region_addr [7] = '{16'h0010, 16'h0050, 16'h0900, 16'hFB10, 16'hFEE8,
    16'hFF10, 16'h8000};
  logic [2:0] region_exp [7] = '{CCRB_RG_VECTOR, CCRB_RG_TABLE, CCRB_RG_FIXED, CCRB_RG_RAM,
    CCRB_RG_BANK, CCRB_RG_SFR, CCRB_RG_OTHER};
  ccrb_core_regs #(.RAM_LARGE(1'b1)) i_ccrb_core_regs (
    .clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .op_valid, .op_code,
    .op_len, .op_target, .op_sel, .op_ready, .alu_upd, .alu_sub, .alu_a, .alu_b, .alu_result,
    .cy_we, .cy_in, .gr_rd_idx, .gr_rd_data, .gr_rp_idx, .gr_rp_data, .gr_wr, .gr_wr_idx,
    .gr_wr_data, .gr_rpw, .gr_rpw_idx, .gr_rpw_data, .irq_req, .irq_masked, .irq_low_prio,
    .irq_vector, .irq_accept, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .next_instr_pointer, .proc_status_word, .stack_top_pointer, .bank_active, .pc_region,
    .pc_fault, .sp_fault
  );
  always #5 clk = ~clk;
  // Zero-wait memory, read data one cycle after the request
  always @(posedge clk) begin
    if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
    else if (mem_req) mem_rdata <= mem[mem_addr];
  end
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (op_ready !== 1'b1) begin
      n++;
      if (n > 30) begin
        mismatches++;
        $display("Error at %0t: op_ready timeout", $time);
        stop_test();
      end
      @(negedge clk);
    end
  endtask : wait_ready
  task automatic do_op(input ccrb_op_t c, input logic [15:0] t, input logic [2:0] l,
                       input logic [1:0] s);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_target <= t;
    op_len <= l;
    op_sel <= s;
    wait_ready();
    @(posedge clk);
    op_valid <= 1'b0;
    wait_ready();
  endtask : do_op
  task automatic bus_write(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= w;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(negedge clk);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    d = bus_rdata;
  endtask : bus_read
  task automatic alu(input logic s, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    alu_upd <= 1'b1;
    alu_sub <= s;
    alu_a <= a;
    alu_b <= b;
    @(posedge clk);
    alu_upd <= 1'b0;
    @(negedge clk);
  endtask : alu
  initial begin
    mem[16'h0000] = 8'h34;
    mem[16'h0001] = 8'h12;
    mem[16'h0006] = 8'h00;
    mem[16'h0007] = 8'h40;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wait_ready();
    check(next_instr_pointer, 16'h1234);
    check(sp_fault, 1'b1);
    bus_read(CCRB_OFS_PSW);
    check(d, CCRB_PSW_RESET);
    bus_read(8'h10);
    check(d, 8'h00);
    bus_write(CCRB_OFS_PC_LO, 8'hFF);
    check(next_instr_pointer, 16'h1234);
    do_op(CCRB_OP_SEQ, 16'h0000, 3'd3, 2'd0);
    check(next_instr_pointer, 16'h1237);
    do_op(CCRB_OP_LOAD_SP, 16'hFEE0, 3'd2, 2'd0);
    check({stack_top_pointer[14:0], sp_fault}, 16'hFDC0);
    do_op(CCRB_OP_BRANCH, 16'h2000, 3'd3, 2'd0);
    check(next_instr_pointer, 16'h2000);
    do_op(CCRB_OP_CALL, 16'h3000, 3'd3, 2'd0);
    check(next_instr_pointer ^ stack_top_pointer, 16'h3000 ^ 16'hFEDE);
    check({mem[16'hFEDF], mem[16'hFEDE]}, 16'h2003);
    do_op(CCRB_OP_RET, 16'h0000, 3'd1, 2'd0);
    check(next_instr_pointer ^ stack_top_pointer, 16'h2003 ^ 16'hFEE0);
    alu(1'b0, 8'hFF, 8'h01);
    check({alu_result, proc_status_word}, 16'h0053);
    alu(1'b1, 8'h10, 8'h01);
    check({alu_result, proc_status_word}, 16'h0F12);
    do_op(CCRB_OP_BANK_SWITCH, 16'h0000, 3'd2, 2'd2);
    check({bank_active, proc_status_word}, 16'h0232);
    @(posedge clk);
    gr_rpw <= 1'b1;
    gr_rpw_idx <= 2'd1;
    gr_rpw_data <= 16'hA55A;
    gr_rp_idx <= 2'd1;
    gr_rd_idx <= 3'd3;
    @(posedge clk);
    gr_rpw <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(gr_rp_data, 16'hA55A);
    check(gr_rd_data, 8'hA5);
    do_op(CCRB_OP_MASK_ALL, 16'h0000, 3'd1, 2'd0);
    check({proc_status_word, 7'h00, irq_accept}, 16'h3200);
    do_op(CCRB_OP_UNMASK, 16'h0000, 3'd1, 2'd0);
    check(proc_status_word, 8'hB2);
    @(posedge clk);
    irq_req <= 1'b1;
    irq_vector <= 16'h0006;
    @(negedge clk);
    check(irq_accept, 1'b1);
    @(posedge clk);
    irq_req <= 1'b0;
    wait_ready();
    check(next_instr_pointer ^ stack_top_pointer, 16'h4000 ^ 16'hFEDD);
    check(proc_status_word, 8'h30);
    check({mem[16'hFEDF], mem[16'hFEDE]}, 16'hB220);
    check(mem[16'hFEDD], 8'h07);
    do_op(CCRB_OP_UNMASK, 16'h0000, 3'd1, 2'd0);
    @(posedge clk);
    irq_req <= 1'b1;
    irq_low_prio <= 1'b1;
    @(negedge clk);
    check(irq_accept, 1'b0);
    @(posedge clk);
    irq_low_prio <= 1'b0;
    irq_masked <= 1'b1;
    @(negedge clk);
    check(irq_accept, 1'b0);
    @(posedge clk);
    irq_req <= 1'b0;
    irq_masked <= 1'b0;
    do_op(CCRB_OP_IRQ_RETURN, 16'h0000, 3'd1, 2'd0);
    check(next_instr_pointer ^ stack_top_pointer, 16'h2007 ^ 16'hFEE0);
    check(proc_status_word, 8'hB2);
    do_op(CCRB_OP_PUSH_PSW, 16'h0000, 3'd1, 2'd0);
    check({mem[16'hFEDF], stack_top_pointer[7:0]}, 16'hB2DF);
    bus_write(CCRB_OFS_PSW, 8'h00);
    check(proc_status_word, 8'h00);
    do_op(CCRB_OP_POP_PSW, 16'h0000, 3'd1, 2'd0);
    check({proc_status_word, stack_top_pointer[7:0]}, 16'hB2E0);
    for (int i = 0; i < 7; i++) begin
      do_op(CCRB_OP_BRANCH, region_addr[i], 3'd3, 2'd0);
      check(pc_region, region_exp[i]);
      check(pc_fault, i == 4);
    end
    stop_test();
  end
endmodule : test_ccrb_core_regs
